// File: verilog/bst_pkg.sv
// Constants and types shared by the boundary-scan test access port
package bst_pkg;
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam int BSR_W = 8;
	localparam logic [2:0] OP_EXTEST = 3'h0;
	localparam logic [2:0] OP_IDCODE = 3'h1;
	localparam logic [2:0] OP_SAMPLE = 3'h2;
	localparam logic [2:0] OP_HIGHZ = 3'h3;
	localparam logic [2:0] OP_CLAMP = 3'h4;
	localparam logic [2:0] OP_BYPASS = 3'h7;
	localparam logic [2:0] IR_CAPTURE = 3'h1;
	// Identification fields: arbitrary neutral values
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART = 16'h00a5;
	localparam logic [10:0] ID_MAKER = 11'h05a;
	localparam logic ID_ONE = 1'b1;
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
		ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} bst_state_t;
endpackage

// File: verilog/bst_tap.sv
// Boundary-scan test access port with mode control of the device pins
`timescale 1ns/1ps

module bst_tap (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic test_clock_pin,
	input wire logic testRst,
	input wire logic testMode,
	input wire logic testDataIn,
	output logic testDataOut,
	output logic testDataOutEn,
	input wire logic [bst_pkg::BSR_W-1:0] funcOut,
	input wire logic [bst_pkg::BSR_W-1:0] funcOutEn,
	input wire logic [bst_pkg::BSR_W-1:0] pinIn,
	output logic [bst_pkg::BSR_W-1:0] pinOut,
	output logic [bst_pkg::BSR_W-1:0] pinOutEn,
	output logic [bst_pkg::BSR_W-1:0] coreIn
);
	localparam int W = bst_pkg::BSR_W;
	localparam int SW = 3 * W;

	// ****************************************************************
	// Test clock domain
	// ****************************************************************
	bst_pkg::bst_state_t state_reg, state_next;
	logic [2:0] ir_reg, ir_next, irSh_reg, irSh_next;
	logic [31:0] id_reg, id_next;
	logic byp_reg, byp_next;
	logic [SW-1:0] bsr_reg, bsr_next, upd_reg, upd_next;
	logic tdo_reg, tdo_next, tdoEn_reg, tdoEn_next;
	logic [2:0] op;
	logic selBsr, selId;
	// Scan chain order: pin inputs, output values, output enables
	logic [SW-1:0] capVec;
	// Pins and core outputs come from another clock: two test clock stages
	logic [SW-1:0] capS1_reg, capS2_reg;

	assign capVec = capS2_reg;
	// Unassigned codes fall to bypass
	assign op = (ir_reg == 3'h5 || ir_reg == 3'h6) ?
		bst_pkg::OP_BYPASS : ir_reg;
	assign selBsr = (op == bst_pkg::OP_EXTEST) ||
		(op == bst_pkg::OP_SAMPLE);
	assign selId = (op == bst_pkg::OP_IDCODE);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
		bst_pkg::ST_RESET: begin
			if (!testMode) begin
				state_next = bst_pkg::ST_IDLE;
			end
		end
		bst_pkg::ST_IDLE: begin
			if (testMode) begin
				state_next = bst_pkg::ST_SEL_DR;
			end
		end
		bst_pkg::ST_SEL_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_SEL_IR;
			end else begin
				state_next = bst_pkg::ST_CAP_DR;
			end
		end
		bst_pkg::ST_CAP_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_EX1_DR;
			end else begin
				state_next = bst_pkg::ST_SH_DR;
			end
		end
		bst_pkg::ST_SH_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_EX1_DR;
			end
		end
		bst_pkg::ST_EX1_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_UPD_DR;
			end else begin
				state_next = bst_pkg::ST_PAU_DR;
			end
		end
		bst_pkg::ST_PAU_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_EX2_DR;
			end
		end
		bst_pkg::ST_EX2_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_UPD_DR;
			end else begin
				state_next = bst_pkg::ST_SH_DR;
			end
		end
		bst_pkg::ST_UPD_DR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_SEL_DR;
			end else begin
				state_next = bst_pkg::ST_IDLE;
			end
		end
		bst_pkg::ST_SEL_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_RESET;
			end else begin
				state_next = bst_pkg::ST_CAP_IR;
			end
		end
		bst_pkg::ST_CAP_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_EX1_IR;
			end else begin
				state_next = bst_pkg::ST_SH_IR;
			end
		end
		bst_pkg::ST_SH_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_EX1_IR;
			end
		end
		bst_pkg::ST_EX1_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_UPD_IR;
			end else begin
				state_next = bst_pkg::ST_PAU_IR;
			end
		end
		bst_pkg::ST_PAU_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_EX2_IR;
			end
		end
		bst_pkg::ST_EX2_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_UPD_IR;
			end else begin
				state_next = bst_pkg::ST_SH_IR;
			end
		end
		bst_pkg::ST_UPD_IR: begin
			if (testMode) begin
				state_next = bst_pkg::ST_SEL_DR;
			end else begin
				state_next = bst_pkg::ST_IDLE;
			end
		end
		default: begin
			state_next = bst_pkg::ST_RESET;
		end
		endcase
	end

	always_comb begin
		ir_next = ir_reg;
		irSh_next = irSh_reg;
		id_next = id_reg;
		byp_next = byp_reg;
		bsr_next = bsr_reg;
		upd_next = upd_reg;
		tdoEn_next = 1'b0;
		tdo_next = tdo_reg;
		case (state_reg)
		bst_pkg::ST_RESET: begin
			ir_next = bst_pkg::OP_IDCODE;
		end
		bst_pkg::ST_CAP_IR: begin
			irSh_next = bst_pkg::IR_CAPTURE;
		end
		bst_pkg::ST_SH_IR: begin
			irSh_next = {testDataIn, irSh_reg[2:1]};
		end
		bst_pkg::ST_UPD_IR: begin
			ir_next = irSh_reg;
		end
		bst_pkg::ST_CAP_DR: begin
			byp_next = 1'b0;
			id_next = {bst_pkg::ID_VERSION, bst_pkg::ID_PART,
				bst_pkg::ID_MAKER, bst_pkg::ID_ONE};
			if (selBsr) begin
				bsr_next = capVec;
			end
		end
		bst_pkg::ST_SH_DR: begin
			if (selBsr) begin
				bsr_next = {testDataIn, bsr_reg[SW-1:1]};
			end else if (selId) begin
				id_next = {testDataIn, id_reg[31:1]};
			end else begin
				byp_next = testDataIn;
			end
		end
		bst_pkg::ST_UPD_DR: begin
			if (selBsr) begin
				upd_next = bsr_reg;
			end
		end
		default: begin
		end
		endcase
		// Data out changes on the falling edge in the standard; here it
		// is registered on the rising edge feeding the shift stage.
		if (state_next == bst_pkg::ST_SH_IR) begin
			tdoEn_next = 1'b1;
			tdo_next = irSh_next[0];
		end else if (state_next == bst_pkg::ST_SH_DR) begin
			tdoEn_next = 1'b1;
			tdo_next = selBsr ? bsr_next[0] :
				(selId ? id_next[0] : byp_next);
		end
	end

	// Test reset is sampled on the test clock only; hold it two edges
	always_ff @(posedge test_clock_pin) begin
		if (testRst) begin
			state_reg <= bst_pkg::ST_RESET;
			ir_reg <= bst_pkg::OP_IDCODE;
			irSh_reg <= 3'h0;
			id_reg <= 32'h0000_0000;
			byp_reg <= 1'b0;
			bsr_reg <= '0;
			upd_reg <= '0;
			tdo_reg <= 1'b0;
			tdoEn_reg <= 1'b0;
			capS1_reg <= '0;
			capS2_reg <= '0;
		end else begin
			capS1_reg <= {funcOutEn, funcOut, pinIn};
			capS2_reg <= capS1_reg;
			state_reg <= state_next;
			ir_reg <= ir_next;
			irSh_reg <= irSh_next;
			id_reg <= id_next;
			byp_reg <= byp_next;
			bsr_reg <= bsr_next;
			upd_reg <= upd_next;
			tdo_reg <= tdo_next;
			tdoEn_reg <= tdoEn_next;
		end
	end

	assign testDataOut = tdo_reg;
	assign testDataOutEn = tdoEn_reg;

	// ****************************************************************
	// Pin mode control on the system clock
	// ****************************************************************
	// Instruction and latch are quasi-static: they move only in update
	// states and the reset state, so a two-stage sync settles well before pins are used.
	logic [2:0] opS1_reg, opS2_reg;
	logic [SW-1:0] updS1_reg, updS2_reg;
	logic [W-1:0] pinOut_reg, pinOut_next;
	logic [W-1:0] pinOutEn_reg, pinOutEn_next;
	logic [W-1:0] pinS1_reg, pinS2_reg;
	logic [W-1:0] coreIn_reg, coreIn_next;

	always_comb begin
		pinOut_next = funcOut;
		pinOutEn_next = funcOutEn;
		coreIn_next = pinS2_reg;
		case (opS2_reg)
		bst_pkg::OP_EXTEST: begin
			pinOut_next = updS2_reg[2*W-1:W];
			pinOutEn_next = updS2_reg[SW-1:2*W];
		end
		bst_pkg::OP_HIGHZ: begin
			pinOutEn_next = '0;
		end
		bst_pkg::OP_CLAMP: begin
			pinOut_next = updS2_reg[2*W-1:W];
			pinOutEn_next = updS2_reg[SW-1:2*W];
		end
		default: begin
		end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			opS1_reg <= bst_pkg::OP_IDCODE;
			opS2_reg <= bst_pkg::OP_IDCODE;
			updS1_reg <= '0;
			updS2_reg <= '0;
			pinS1_reg <= '0;
			pinS2_reg <= '0;
			pinOut_reg <= '0;
			pinOutEn_reg <= '0;
			coreIn_reg <= '0;
		end else begin
			opS1_reg <= op;
			opS2_reg <= opS1_reg;
			updS1_reg <= upd_reg;
			updS2_reg <= updS1_reg;
			pinS1_reg <= pinIn;
			pinS2_reg <= pinS1_reg;
			pinOut_reg <= pinOut_next;
			pinOutEn_reg <= pinOutEn_next;
			coreIn_reg <= coreIn_next;
		end
	end

	assign pinOut = pinOut_reg;
	assign pinOutEn = pinOutEn_reg;
	assign coreIn = coreIn_reg;
endmodule

// File: tb/bst_ctl_model.sv
// Test controller model that drives the scan link
`timescale 1ns/1ps
module bst_ctl_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst,
	input wire logic tdo
);
	logic nc;
	// Clock rests low between frames; mode and data lines start high as if pulled up, reset starts low
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst = 1'b0;
	end
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#62.5 tck = 1'b1;
		#62.5 tck = 1'b0;
		q = tdo;
	endtask
	task automatic linkReset();
		#1.3;
		trst = 1'b1;
		repeat (2) tick(1'b1, 1'b1, nc);
		trst = 1'b0;
		tick(1'b0, 1'b1, nc);
	endtask
	task automatic tmsReset();
		#1.3;
		repeat (5) tick(1'b1, 1'b1, nc);
		tick(1'b0, 1'b1, nc);
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		dout = '0;
		#1.3;
		tick(1'b1, 1'b1, nc);
		if (ir) tick(1'b1, 1'b1, nc);
		tick(1'b0, 1'b1, nc);
		tick(1'b0, 1'b1, dout[0]);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], nc);
			if (i < n - 1) dout[i + 1] = nc;
		end
		tick(1'b1, 1'b1, nc);
		tick(1'b0, 1'b1, nc);
	endtask
endmodule

// File: tb/bst_tap_props.sv
// Concurrent checks on the scan link of the test access port
`timescale 1ns/1ps
module bst_tap_props (
	input wire logic test_clock_pin,
	input wire logic testRst,
	input wire logic testMode,
	input wire logic testDataOut,
	input wire logic testDataOutEn
);
	default clocking @(posedge test_clock_pin); endclocking
	default disable iff (testRst);
	// Idle, then select and capture, ending on the edge into shift
	sequence toDr;
		!testMode ##1 testMode ##1 !testMode [*2];
	endsequence
	sequence toIr;
		!testMode ##1 testMode [*2] ##1 !testMode [*2];
	endsequence
	chk_reset_id: assert property ($fell(testRst) ##0 toDr |=>
		testDataOutEn && testDataOut) else $error("no id after reset");
	chk_reset_quiet: assert property ($fell(testRst) |->
		!testDataOutEn [*4]) else $error("shift too soon");
	chk_tms_id: assert property (testMode [*5] ##1 toDr |=>
		testDataOut ##1 testDataOut == bst_pkg::ID_MAKER[0])
		else $error("bad id after mode reset");
	chk_ir_capture: assert property (testMode [*5] ##1 toIr |=>
		testDataOut ##1 !testDataOut) else $error("bad ir capture");
	chk_tms_exit: assert property (testMode [*5] |=>
		!testDataOutEn) else $error("shift after mode reset");
	chk_shift_hold: assert property (testDataOutEn && !testMode |=>
		testDataOutEn) else $error("left shift early");
	chk_shift_leave: assert property (testDataOutEn && testMode |=>
		!testDataOutEn) else $error("stayed in shift");
	chk_no_entry: assert property (!testDataOutEn && testMode |=>
		!testDataOutEn) else $error("shift on high mode");
endmodule
bind bst_tap bst_tap_props i_bst_tap_props (.test_clock_pin, .testRst,
	.testMode, .testDataOut, .testDataOutEn);

// File: tb/bst_tap_tb_top.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
module bst_tap_tb_top;
	typedef logic [bst_pkg::BSR_W-1:0] bst_pins_t;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic test_clock_pin, testRst, testMode, testDataIn, testDataOut;
	logic testDataOutEn;
	bst_pins_t funcOut = '0, funcOutEn = '0, pinIn = '0;
	bst_pins_t pinOut, pinOutEn, coreIn;
	logic [23:0] latch = '0;
	logic [31:0] d, x;
	logic [2:0] op;
	logic [2:0] ops [8] = '{3'h2, 3'h0, 3'h4, 3'h3, 3'h1, 3'h5, 3'h6, 3'h7};
	int seed = 32'h0000_136a;
	int n_errors = 0;
	int n_compared = 0;
	always #2.5 mclk = ~mclk;
	bst_tap i_bst_tap (.mclk, .sys_rst, .test_clock_pin, .testRst, .testMode,
		.testDataIn, .testDataOut, .testDataOutEn, .funcOut, .funcOutEn,
		.pinIn, .pinOut, .pinOutEn, .coreIn);
	bst_ctl_model i_bst_ctl_model (.tck(test_clock_pin), .tms(testMode),
		.tdi(testDataIn), .trst(testRst),
		.tdo(testDataOutEn ? testDataOut : 1'bz));
	function automatic int drLen(input logic [2:0] o);
		if (o == bst_pkg::OP_IDCODE)
			return 32;
		return (o inside {bst_pkg::OP_EXTEST, bst_pkg::OP_SAMPLE}) ? 24 : 2;
	endfunction
	function automatic logic [31:0] expDr(input logic [2:0] o);
		if (o == bst_pkg::OP_IDCODE)
			return {bst_pkg::ID_VERSION, bst_pkg::ID_PART, bst_pkg::ID_MAKER,
				bst_pkg::ID_ONE};
		if (o == bst_pkg::OP_SAMPLE)
			return {8'h00, funcOutEn, funcOut, pinIn};
		if (o == bst_pkg::OP_EXTEST)
			return {24'h00_0000, pinIn};
		return {30'h0000_0000, x[0], 1'b0};
	endfunction
	function automatic logic [15:0] expPins(input logic [2:0] o);
		if (o == bst_pkg::OP_HIGHZ)
			return 16'h0000;
		if (o == bst_pkg::OP_EXTEST || o == bst_pkg::OP_CLAMP)
			return latch[23:8];
		return {funcOutEn, funcOut};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		i_bst_ctl_model.linkReset();
		i_bst_ctl_model.scan(1'b0, 32, 32'h0000_0000, d);
		chk(d, expDr(bst_pkg::OP_IDCODE));
		// Sample first so the later drive codes use preloaded data
		for (int k = 0; k < 8; k++) begin
			op = ops[k];
			@(posedge mclk);
			{funcOut, funcOutEn, pinIn} <= 24'($random(seed));
			i_bst_ctl_model.scan(1'b1, 3, {29'h0000_0000, op}, d);
			chk(d, 32'h0000_0001);
			repeat (4) @(posedge mclk);
			chk({16'h0000, pinOutEn, op == 3'h3 ? 8'h00 : pinOut},
				{16'h0000, expPins(op)});
			x = $random(seed);
			i_bst_ctl_model.scan(1'b0, drLen(op), x, d);
			chk(op == 3'h0 ? {24'h00_0000, d[7:0]} : d, expDr(op));
			if (drLen(op) == 24) latch = x[23:0];
		end
		i_bst_ctl_model.tmsReset();
		i_bst_ctl_model.scan(1'b1, 3, 32'h0000_0007, d);
		chk(d, 32'h0000_0001);
		i_bst_ctl_model.tmsReset();
		i_bst_ctl_model.scan(1'b0, 32, 32'h0000_0000, d);
		chk(d, expDr(bst_pkg::OP_IDCODE));
		end_sim();
	end
	initial begin
		#300_000;
		n_errors++;
		end_sim();
	end
endmodule
